// *** core/pmm_defines.svh ***
// constants for the power-managed mode controller
`ifndef PMM_DEFINES_SVH
`define PMM_DEFINES_SVH

// ==========================================
// register byte offsets
`define PMM_OFF_CTRL 8'h00
`define PMM_OFF_SLEEP 8'h04
`define PMM_OFF_INTEN 8'h08
`define PMM_OFF_STATUS 8'h0c

// ==========================================
// field positions and widths
`define PMM_CTRL_W 13
`define PMM_SLEEP_BIT 0
`define PMM_IRQ_W 8
`define PMM_GIE_BIT 8
`define PMM_CSS_SEC 2'h1
`define PMM_CSS_PRI 2'h0

// ==========================================
// reset values
`define PMM_CTRL_RST 13'h0000
`define PMM_INTEN_RST 9'h000
`define PMM_FLAGS_RST 3'h1

// ==========================================
// timing
`define PMM_CLK_NS 40
`define PMM_CSD_NS 1000
`define PMM_SETTLE_NS 1000
`define PMM_PLL_LOCK_NS 2000000
`define PMM_OST_CYCLES 1024

`endif

// *** core/pmm_pkg.sv ***
// types for the power-managed mode controller
package pmm_pkg;

	// ==========================================
	// operating state, gray coded along the path
	typedef enum logic [2:0] {
		PMM_ST_RUN = 3'h0,
		PMM_ST_IDLE = 3'h1,
		PMM_ST_WAKE_IDLE = 3'h3,
		PMM_ST_SLEEP = 3'h2,
		PMM_ST_WAKE_SLEEP = 3'h6
	} pmm_state_t;

	// ==========================================
	// software control word, msb first
	typedef struct packed {
		logic pll_en;
		logic crystal;
		logic fscm_en;
		logic two_speed;
		logic wdt_en;
		logic low_freq_source_select;
		logic [2:0] internal_freq_select;
		logic secondary_osc_enable;
		logic [1:0] clock_source_select;
		logic idle_on_sleep_select;
	} pmm_ctrl_t;

	// ==========================================
	// clock source status flags
	typedef struct packed {
		logic secondary_clock_active_flag;
		logic fast_osc_stable_flag;
		logic primary_clock_ready_flag;
	} pmm_flags_t;

endpackage : pmm_pkg

// *** core/pmm_sync.sv ***
// two-stage synchroniser for asynchronous inputs
`timescale 1ns/1ps

module pmm_sync #(
	parameter int WIDTH = 1
) (
	input logic pclk,
	input logic presetn,
	input logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= '0;
			sync_out <= '0;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule : pmm_sync

// *** core/pmm_ctrl.sv ***
// power-managed sleep and idle mode controller with apb registers
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "pmm_defines.svh"

// Behaviour
// - sleep command with idle select clear enters sleep, stopping oscillator and clocks
// - entering sleep clears primary ready, fast stable and secondary active flags
// - low-power rc runs if watchdog on; secondary osc runs if enabled
// - after sleep wake, stay unclocked until selected source ready, unless two-speed/fail-safe
// - primary ready flag sets once primary clock drives the device after sleep
// - wake-up never alters idle select or clock source select
// - sleep command with idle select set stops cpu clock; flags unchanged in primary idle
// - idle exits only on interrupt, watchdog time-out or reset
// - after idle wake, hold cpu for start delay, then resume same source
// - watchdog time-out in sleep or idle wakes to run mode, not reset
// - primary idle keeps primary clock running and primary ready flag set
// - secondary idle shuts primary, clears primary flag, sets secondary active flag
// - secondary idle request ignored when secondary oscillator disabled
// - peripheral clocks held until secondary oscillator runs
// - upper select bit uses internal oscillator, shuts primary, clears primary flag
// - non-zero frequency or source select enables fast osc; stable flag after settling
// - fast stable flag kept if already stable; clear when selects all zero
// - low-power rc keeps running in internal idle if watchdog or fail-safe on
// - enabled interrupt flag starts exit from sleep or idle immediately
// - interrupt exit branches to vector only when global interrupt enable set
// - execution restarts on the first cycle after the start delay
// - crystal restart counts 1024 oscillator cycles, then pll lock if multiplier
// - flags show primary, secondary or stable fast internal source driving device
// - mode entered depends on idle select at the sleep command
module pmm_ctrl #(
	parameter int ADDR_W = 8,
	parameter int OST_CYCLES = `PMM_OST_CYCLES,
	parameter int PLL_LOCK_CYC = (`PMM_PLL_LOCK_NS + `PMM_CLK_NS - 1) / `PMM_CLK_NS
) (
	input logic pclk,
	input logic presetn,
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [ADDR_W-1:0] paddr,
	input logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input logic [`PMM_IRQ_W-1:0] irq_flag_pin,
	input logic wdt_timeout_pin,
	input logic sec_osc_running_pin,
	input logic pri_osc_tick_pin,
	output logic cpu_clk_en,
	output logic periph_clk_en,
	output logic primary_osc_en,
	output logic fast_osc_en,
	output logic lp_rc_en,
	output logic sec_osc_en,
	output logic exec_resume,
	output logic branch_to_vector,
	output pmm_pkg::pmm_flags_t clk_flags
);
	import pmm_pkg::*;

	function automatic int ceil_cyc(input int ns);
		int c;
		c = (ns + `PMM_CLK_NS - 1) / `PMM_CLK_NS;
		ceil_cyc = (c < 1) ? 1 : c;
	endfunction : ceil_cyc

	localparam int CSD_CYC = ceil_cyc(`PMM_CSD_NS);
	localparam int SETTLE_CYC = ceil_cyc(`PMM_SETTLE_NS);
	localparam int CSD_W = $clog2(CSD_CYC + 1);
	localparam int SET_W = $clog2(SETTLE_CYC + 1);
	localparam int OST_W = $clog2(OST_CYCLES + 1);
	localparam int PLL_W = $clog2(PLL_LOCK_CYC + 1);

	// ==========================================
	// input synchronisers
	logic [`PMM_IRQ_W+2:0] pins_s;
	logic [`PMM_IRQ_W-1:0] irq_s;
	logic wdt_s;
	logic secondary_run_mode_s;
	logic tick_s;
	logic tick_d1_q;

	pmm_sync #(.WIDTH(`PMM_IRQ_W + 3)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in({pri_osc_tick_pin, sec_osc_running_pin, wdt_timeout_pin, irq_flag_pin}),
		.sync_out(pins_s)
	);

	assign irq_s = pins_s[`PMM_IRQ_W-1:0];
	assign wdt_s = pins_s[`PMM_IRQ_W];
	assign secondary_run_mode_s = pins_s[`PMM_IRQ_W+1];
	assign tick_s = pins_s[`PMM_IRQ_W+2];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_d1_q <= 1'b0;
		end else begin
			tick_d1_q <= tick_s;
		end
	end

	// ==========================================
	// apb register file
	pmm_ctrl_t ctrl_q;
	logic [`PMM_IRQ_W:0] inten_q;
	logic sleep_cmd_q;
	pmm_state_t state_q;
	pmm_state_t state_d;
	logic apb_setup;
	logic apb_wr;
	logic [31:0] rd_mux;
	logic rd_err;

	assign apb_setup = psel && !penable;
	assign apb_wr = psel && penable && pready && pwrite;

	always_comb begin
		rd_mux = 32'h0;
		rd_err = 1'b0;
		case (paddr)
			`PMM_OFF_CTRL: rd_mux = {{(32-`PMM_CTRL_W){1'b0}}, ctrl_q};
			`PMM_OFF_SLEEP: rd_mux = 32'h0;
			`PMM_OFF_INTEN: rd_mux = {{(31-`PMM_IRQ_W){1'b0}}, inten_q};
			`PMM_OFF_STATUS: rd_mux = {24'h0, state_q, periph_clk_en, cpu_clk_en, clk_flags};
			default: rd_err = 1'b1;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= apb_setup;
			pslverr <= apb_setup && rd_err;
			prdata <= (apb_setup && !pwrite) ? rd_mux : 32'h0;
		end
	end

	// control bits change only by software, never by wake-up
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `PMM_CTRL_RST;
			inten_q <= `PMM_INTEN_RST;
			sleep_cmd_q <= 1'b0;
		end else begin
			sleep_cmd_q <= apb_wr && (paddr == `PMM_OFF_SLEEP) && pwdata[`PMM_SLEEP_BIT];
			if (apb_wr && (paddr == `PMM_OFF_CTRL)) begin
				ctrl_q <= pwdata[`PMM_CTRL_W-1:0];
			end
			if (apb_wr && (paddr == `PMM_OFF_INTEN)) begin
				inten_q <= pwdata[`PMM_IRQ_W:0];
			end
		end
	end

	// ==========================================
	// wake sources and clock readiness
	logic irq_wake;
	logic wake;
	logic early_int;
	logic fast_needed;
	logic css_pri;
	logic css_sec;
	logic ost_done_q;
	logic pll_done_q;
	logic pri_ready;
	logic src_ready;
	logic [OST_W-1:0] ost_cnt_q;
	logic [PLL_W-1:0] pll_cnt_q;
	logic [SET_W-1:0] set_cnt_q;
	logic [CSD_W-1:0] csd_cnt_q;
	logic wake_irq_q;
	logic entering;

	assign irq_wake = |(irq_s & inten_q[`PMM_IRQ_W-1:0]);
	assign wake = irq_wake || wdt_s;
	assign early_int = ctrl_q.two_speed || ctrl_q.fscm_en;
	assign fast_needed = (ctrl_q.internal_freq_select != 3'h0) || ctrl_q.low_freq_source_select;
	assign css_pri = ctrl_q.clock_source_select == `PMM_CSS_PRI;
	assign css_sec = ctrl_q.clock_source_select == `PMM_CSS_SEC;
	assign pri_ready = primary_osc_en && (!ctrl_q.crystal || ost_done_q) && (!ctrl_q.pll_en || pll_done_q);
	assign entering = state_q == PMM_ST_RUN && state_d != PMM_ST_RUN;

	always_comb begin
		case (ctrl_q.clock_source_select)
			`PMM_CSS_PRI: src_ready = pri_ready;
			`PMM_CSS_SEC: src_ready = secondary_run_mode_s;
			default: src_ready = !fast_needed || clk_flags.fast_osc_stable_flag;
		endcase
	end

	// ==========================================
	// mode state machine
	always_comb begin
		state_d = state_q;
		case (state_q)
			PMM_ST_RUN: begin
				if (sleep_cmd_q) begin
					if (!ctrl_q.idle_on_sleep_select) begin
						state_d = PMM_ST_SLEEP;
					end else if (!(css_sec && !ctrl_q.secondary_osc_enable)) begin
						state_d = PMM_ST_IDLE;
					end
				end
			end
			PMM_ST_IDLE: if (wake) state_d = PMM_ST_WAKE_IDLE;
			PMM_ST_WAKE_IDLE: if (csd_cnt_q == '0) state_d = PMM_ST_RUN;
			PMM_ST_SLEEP: if (wake) state_d = PMM_ST_WAKE_SLEEP;
			PMM_ST_WAKE_SLEEP: begin
				if (csd_cnt_q == '0 && (src_ready || early_int)) begin
					state_d = PMM_ST_RUN;
				end
			end
			default: state_d = PMM_ST_RUN;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= PMM_ST_RUN;
			csd_cnt_q <= '0;
			wake_irq_q <= 1'b0;
		end else begin
			state_q <= state_d;
			if ((state_q == PMM_ST_IDLE || state_q == PMM_ST_SLEEP) && wake) begin
				csd_cnt_q <= CSD_W'(CSD_CYC - 1);
				wake_irq_q <= irq_wake;
			end else if (csd_cnt_q != '0) begin
				csd_cnt_q <= csd_cnt_q - 1'b1;
			end
		end
	end

	// ==========================================
	// primary oscillator, start-up timer and pll lock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			primary_osc_en <= 1'b1;
		end else if (state_d == PMM_ST_SLEEP && state_q != PMM_ST_SLEEP) begin
			primary_osc_en <= 1'b0;
		end else if (entering && state_d == PMM_ST_IDLE && !css_pri) begin
			primary_osc_en <= 1'b0;
		end else if (state_q == PMM_ST_WAKE_SLEEP && css_pri) begin
			primary_osc_en <= 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ost_cnt_q <= '0;
			ost_done_q <= 1'b1;
			pll_cnt_q <= '0;
			pll_done_q <= 1'b1;
		end else if (!primary_osc_en) begin
			ost_cnt_q <= '0;
			ost_done_q <= 1'b0;
			pll_cnt_q <= '0;
			pll_done_q <= 1'b0;
		end else begin
			if (!ost_done_q && tick_s && !tick_d1_q) begin
				ost_cnt_q <= ost_cnt_q + 1'b1;
				ost_done_q <= ost_cnt_q == OST_W'(OST_CYCLES - 1);
			end
			if ((ost_done_q || !ctrl_q.crystal) && !pll_done_q) begin
				pll_cnt_q <= pll_cnt_q + 1'b1;
				pll_done_q <= pll_cnt_q == PLL_W'(PLL_LOCK_CYC - 1);
			end
		end
	end

	// ==========================================
	// fast internal oscillator and its settling
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fast_osc_en <= 1'b0;
			set_cnt_q <= '0;
		end else begin
			if (state_d == PMM_ST_SLEEP) begin
				fast_osc_en <= 1'b0;
			end else if (ctrl_q.clock_source_select[1]) begin
				fast_osc_en <= fast_needed;
			end else if (state_q == PMM_ST_WAKE_SLEEP) begin
				fast_osc_en <= early_int;
			end
			if (!fast_osc_en || clk_flags.fast_osc_stable_flag) begin
				set_cnt_q <= '0;
			end else begin
				set_cnt_q <= set_cnt_q + 1'b1;
			end
		end
	end

	// ==========================================
	// clock source status flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_flags <= `PMM_FLAGS_RST;
		end else if (state_d == PMM_ST_SLEEP && state_q != PMM_ST_SLEEP) begin
			clk_flags <= '0;
		end else if (entering && state_d == PMM_ST_IDLE) begin
			if (css_sec) begin
				clk_flags.primary_clock_ready_flag <= 1'b0;
				clk_flags.secondary_clock_active_flag <= 1'b1;
			end else if (!css_pri) begin
				clk_flags.primary_clock_ready_flag <= 1'b0;
				clk_flags.fast_osc_stable_flag <= clk_flags.fast_osc_stable_flag && fast_needed;
			end
		end else begin
			if (css_pri && pri_ready && (state_q == PMM_ST_RUN || state_q == PMM_ST_WAKE_SLEEP)) begin
				clk_flags.primary_clock_ready_flag <= 1'b1;
			end
			if (state_q == PMM_ST_WAKE_SLEEP && state_d == PMM_ST_RUN && css_sec) begin
				clk_flags.secondary_clock_active_flag <= 1'b1;
			end
			if (!fast_osc_en) begin
				clk_flags.fast_osc_stable_flag <= 1'b0;
			end else if (set_cnt_q == SET_W'(SETTLE_CYC - 1)) begin
				clk_flags.fast_osc_stable_flag <= 1'b1;
			end
		end
	end

	// ==========================================
	// clock gates and resume strobes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_clk_en <= 1'b1;
			periph_clk_en <= 1'b1;
		end else begin
			cpu_clk_en <= state_d == PMM_ST_RUN;
			case (state_d)
				PMM_ST_RUN: periph_clk_en <= 1'b1;
				PMM_ST_IDLE, PMM_ST_WAKE_IDLE: periph_clk_en <= !css_sec || secondary_run_mode_s;
				PMM_ST_WAKE_SLEEP: periph_clk_en <= early_int;
				default: periph_clk_en <= 1'b0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			exec_resume <= 1'b0;
			branch_to_vector <= 1'b0;
		end else begin
			exec_resume <= state_q != PMM_ST_RUN && state_d == PMM_ST_RUN;
			branch_to_vector <= state_q != PMM_ST_RUN && state_d == PMM_ST_RUN
				&& wake_irq_q && inten_q[`PMM_GIE_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lp_rc_en <= 1'b0;
			sec_osc_en <= 1'b0;
		end else begin
			lp_rc_en <= ctrl_q.wdt_en || ctrl_q.fscm_en
				|| (ctrl_q.clock_source_select[1] && !fast_needed);
			sec_osc_en <= ctrl_q.secondary_osc_enable;
		end
	end

endmodule : pmm_ctrl

// *** verif/pmm_ctrl_chk.sv ***
// port-level assertions for the power-managed mode controller
`timescale 1ns/1ps

module pmm_ctrl_chk (
	input logic pclk,
	input logic presetn,
	input logic psel,
	input logic penable,
	input logic pready,
	input logic pslverr,
	input logic cpu_clk_en,
	input logic periph_clk_en,
	input logic primary_osc_en,
	input logic fast_osc_en,
	input logic sec_osc_en,
	input logic exec_resume,
	input logic branch_to_vector,
	input pmm_pkg::pmm_flags_t clk_flags
);
	import pmm_pkg::*;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// ==========================================
	// bus answer
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");

	// ==========================================
	// mode entry and exit
	a_sleep_clears_flags: assert property ($fell(cpu_clk_en) && !periph_clk_en && !sec_osc_en |->
		clk_flags == 3'h0 && !primary_osc_en)
		else $error("flags or primary osc left on at sleep entry");
	a_primary_idle_mode_flags: assert property ($fell(cpu_clk_en) && periph_clk_en && primary_osc_en |->
		$stable(clk_flags))
		else $error("flags changed on primary idle entry");
	a_primary_idle_mode_ready: assert property (!cpu_clk_en && periph_clk_en && primary_osc_en && $past(primary_osc_en) |->
		clk_flags.primary_clock_ready_flag)
		else $error("primary ready lost in primary idle");
	a_wake_resumes: assert property ($rose(cpu_clk_en) |-> exec_resume)
		else $error("cpu clock back without resume");
	a_branch_on_exec: assert property (branch_to_vector |-> exec_resume)
		else $error("branch without resume");
	a_resume_pulse: assert property (exec_resume |=> !exec_resume)
		else $error("resume longer than one cycle");

	// ==========================================
	// fast oscillator flag
	a_fast_needs_osc: assert property (!fast_osc_en [*2] |-> !clk_flags.fast_osc_stable_flag)
		else $error("fast stable flag with oscillator off");
	a_fast_settles: assert property ($rose(fast_osc_en) |=> !clk_flags.fast_osc_stable_flag [*8])
		else $error("fast stable flag before settling");

endmodule : pmm_ctrl_chk

// *** verif/pmm_ctrl_test.sv ***
// self-checking bench for the power-managed mode controller
`timescale 1ns/1ps
`include "pmm_defines.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end

module pmm_ctrl_test;
	import pmm_pkg::*;

	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [7:0] irq_flag_pin = 8'h00;
	logic wdt_timeout_pin = 1'b0;
	logic sec_osc_running_pin = 1'b0;
	logic pri_osc_tick_pin = 1'b0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic cpu_clk_en;
	logic periph_clk_en;
	logic primary_osc_en;
	logic fast_osc_en;
	logic lp_rc_en;
	logic sec_osc_en;
	logic exec_resume;
	logic branch_to_vector;
	pmm_flags_t clk_flags;
	int fails = 0;
	int n_compared = 0;
	int cyc = 0;
	int n;
	logic br;
	logic [31:0] rdat;
	logic rerr;
	logic [3:0] tick_cnt = 4'h0;

	always #20 pclk = ~pclk;

	// primary oscillator ticks and hang guard
	always @(posedge pclk) begin
		tick_cnt <= tick_cnt + 4'h1;
		pri_osc_tick_pin <= tick_cnt[1];
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			report_and_stop();
		end
	end

	pmm_ctrl #(.OST_CYCLES(4), .PLL_LOCK_CYC(8)) pmm_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq_flag_pin(irq_flag_pin), .wdt_timeout_pin(wdt_timeout_pin),
		.sec_osc_running_pin(sec_osc_running_pin), .pri_osc_tick_pin(pri_osc_tick_pin),
		.cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .primary_osc_en(primary_osc_en),
		.fast_osc_en(fast_osc_en), .lp_rc_en(lp_rc_en), .sec_osc_en(sec_osc_en), .exec_resume(exec_resume),
		.branch_to_vector(branch_to_vector), .clk_flags(clk_flags));

	// ==========================================
	// tasks
	task report_and_stop();
		if (fails == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : report_and_stop

	task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		`CHK("pready", 1'b1, pready)
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

	task chkrd(input string nm, input logic [7:0] a, input logic [31:0] e);
		xfer(a, 1'b0, 32'h0);
		`CHK(nm, e, rdat)
	endtask : chkrd

	task do_sleep();
		xfer(`PMM_OFF_SLEEP, 1'b1, 32'h1);
		repeat (3) @(posedge pclk);
		@(negedge pclk);
	endtask : do_sleep

	task wake(input logic [7:0] irq, input logic wdt);
		@(posedge pclk);
		irq_flag_pin <= irq;
		wdt_timeout_pin <= wdt;
		n = 0;
		do begin
			@(negedge pclk);
			n++;
		end while (exec_resume !== 1'b1 && n < 300);
		br = branch_to_vector;
		`CHK("wake", 1'b1, exec_resume)
		@(posedge pclk);
		irq_flag_pin <= 8'h00;
		wdt_timeout_pin <= 1'b0;
	endtask : wake

	task settle();
		repeat (30) @(posedge pclk);
		@(negedge pclk);
	endtask : settle

	// ==========================================
	// main sequence
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		`CHK("flags_rst", 3'h1, clk_flags)
		`CHK("cpu_rst", 1'b1, cpu_clk_en)
		chkrd("ctrl_rst", `PMM_OFF_CTRL, 32'h0);
		chkrd("inten_rst", `PMM_OFF_INTEN, 32'h0);
		chkrd("unmapped", 8'h10, 32'h0);
		`CHK("unmapped_err", 1'b1, rerr)
		// primary idle, interrupt wake with branch
		xfer(`PMM_OFF_INTEN, 1'b1, 32'h101);
		xfer(`PMM_OFF_CTRL, 1'b1, 32'h1);
		do_sleep();
		`CHK("pidle_cpu", 1'b0, cpu_clk_en)
		`CHK("pidle_per", 1'b1, periph_clk_en)
		chkrd("pidle_stat", `PMM_OFF_STATUS, 32'h31);
		wake(8'h01, 1'b0);
		`CHK("pidle_br", 1'b1, br)
		`CHK("pidle_csd", 1'b1, n > 24)
		`CHK("pidle_flags", 3'h1, clk_flags)
		chkrd("pidle_ctrl", `PMM_OFF_CTRL, 32'h1);
		// disabled interrupt ignored, watchdog wakes
		do_sleep();
		@(posedge pclk);
		irq_flag_pin <= 8'h02;
		settle();
		`CHK("idle_hold", 1'b0, cpu_clk_en)
		wake(8'h02, 1'b1);
		`CHK("wdt_br", 1'b0, br)
		`CHK("wdt_cpu", 1'b1, cpu_clk_en)
		// sleep with crystal, multiplier and watchdog
		xfer(`PMM_OFF_CTRL, 1'b1, 32'h1900);
		do_sleep();
		`CHK("slp_cpu", 1'b0, cpu_clk_en)
		`CHK("slp_per", 1'b0, periph_clk_en)
		`CHK("slp_pri", 1'b0, primary_osc_en)
		`CHK("slp_flags", 3'h0, clk_flags)
		`CHK("slp_lprc", 1'b1, lp_rc_en)
		chkrd("slp_stat", `PMM_OFF_STATUS, 32'h40);
		wake(8'h01, 1'b0);
		`CHK("slp_ready", 3'h1, clk_flags)
		`CHK("slp_csd", 1'b1, n > 24)
		// secondary idle refused, then entered before the oscillator runs
		xfer(`PMM_OFF_CTRL, 1'b1, 32'h3);
		do_sleep();
		`CHK("sec_refused", 1'b1, cpu_clk_en)
		xfer(`PMM_OFF_CTRL, 1'b1, 32'hb);
		do_sleep();
		`CHK("sec_cpu", 1'b0, cpu_clk_en)
		`CHK("sec_per", 1'b0, periph_clk_en)
		`CHK("sec_flags", 3'h4, clk_flags)
		`CHK("sec_pri", 1'b0, primary_osc_en)
		`CHK("sec_osc", 1'b1, sec_osc_en)
		@(posedge pclk);
		sec_osc_running_pin <= 1'b1;
		settle();
		`CHK("sec_per_on", 1'b1, periph_clk_en)
		wake(8'h00, 1'b1);
		`CHK("sec_resume", 3'h4, clk_flags)
		chkrd("sec_ctrl", `PMM_OFF_CTRL, 32'hb);
		// internal oscillator idle with and without fast oscillator
		xfer(`PMM_OFF_CTRL, 1'b1, 32'h175);
		do_sleep();
		`CHK("rc_pri", 1'b0, primary_osc_en)
		`CHK("rc_flag", 1'b0, clk_flags.primary_clock_ready_flag)
		`CHK("rc_lprc", 1'b1, lp_rc_en)
		`CHK("rc_fast", 1'b1, fast_osc_en)
		settle();
		`CHK("rc_stable", 1'b1, clk_flags.fast_osc_stable_flag)
		`CHK("rc_per", 1'b1, periph_clk_en)
		wake(8'h01, 1'b0);
		xfer(`PMM_OFF_CTRL, 1'b1, 32'h105);
		do_sleep();
		settle();
		`CHK("rc_nofast", 1'b0, clk_flags.fast_osc_stable_flag)
		`CHK("rc_fast_off", 1'b0, fast_osc_en)
		wake(8'h00, 1'b1);
		// two-speed sleep wake clocks peripherals before the cpu
		xfer(`PMM_OFF_CTRL, 1'b1, 32'h200);
		do_sleep();
		`CHK("ts_per_off", 1'b0, periph_clk_en)
		@(posedge pclk);
		irq_flag_pin <= 8'h01;
		repeat (8) @(posedge pclk);
		@(negedge pclk);
		`CHK("ts_per", 1'b1, periph_clk_en)
		`CHK("ts_fast", 1'b1, fast_osc_en)
		`CHK("ts_cpu", 1'b0, cpu_clk_en)
		wake(8'h01, 1'b0);
		`CHK("ts_pri", 1'b1, clk_flags.primary_clock_ready_flag)
		`CHK("ts_br", 1'b1, br)
		report_and_stop();
	end

endmodule : pmm_ctrl_test

bind pmm_ctrl pmm_ctrl_chk pmm_ctrl_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pready(pready), .pslverr(pslverr), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
	.primary_osc_en(primary_osc_en), .fast_osc_en(fast_osc_en), .sec_osc_en(sec_osc_en),
	.exec_resume(exec_resume), .branch_to_vector(branch_to_vector), .clk_flags(clk_flags));
